// ### rtl/odac_pkg.sv
// Constants shared by the output update control logic
`default_nettype none
package odac_pkg;
  localparam int          CHANNELS        = 8;
  localparam int          CODE_WIDTH      = 16;
  localparam int          ADDR_WIDTH      = 5;
  localparam int          SYNC_STAGES     = 2;
  // Channel data registers sit at addresses 0x08..0x0F
  localparam logic [1:0]  DATA_BANK_SEL   = 2'h1;
  localparam int          BANK_SEL_POS    = 3;
  localparam int          CHAN_SEL_WIDTH  = 3;
  // Reset levels chosen by the reset level select pin
  localparam logic [15:0] RESET_CODE_ZERO = 16'h0000;
  localparam logic [15:0] RESET_CODE_MID  = 16'h8000;
  // Cycles after reset release before the load pin is sampled as a strap
  localparam logic [1:0]  STRAP_DELAY     = 2'h2;
  typedef enum logic [1:0] {
    ODAC_WAIT_STRAP = 2'b00,
    ODAC_MODE_SYNC  = 2'b01,
    ODAC_MODE_ASYNC = 2'b10
  } odac_mode_type;
endpackage
`default_nettype wire

// ### rtl/odac_sync.sv
// Two-flop synchroniser for pin levels
`default_nettype none
module odac_sync #(
  parameter int          WIDTH = 1,
  parameter logic [15:0] INIT  = 16'h0000
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_pin,
  output var  logic [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] stage1;

  ////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      stage1  <= INIT[WIDTH-1:0];
      o_level <= INIT[WIDTH-1:0];
    end else begin
      stage1  <= i_pin;
      o_level <= stage1;
    end
  end
endmodule
`default_nettype wire

// ### rtl/odac_update_ctrl.sv
// Output update control of the eight-channel converter
// Host pins pass two flops; every code and flag leaves the block from a flop.
`default_nettype none
module odac_update_ctrl
  import odac_pkg::*;
(
  input  wire logic                                    I_CLOCK,
  input  wire logic                                    I_SYS_RST,
  input  wire logic                                    I_OUTPUT_CLAMP_N,
  input  wire logic                                    I_LATCH_LOAD_N,
  input  wire logic                                    I_RESET_N,
  input  wire logic                                    I_RESET_LEVEL_SELECT,
  input  wire logic                                    I_ENGINE_ACTIVE,
  input  wire logic                                    I_WRITE,
  input  wire logic [odac_pkg::ADDR_WIDTH-1:0]         I_ADDRESS,
  input  wire logic [odac_pkg::CODE_WIDTH-1:0]         I_DATA,
  output var  logic                                    O_BUSY_OUT,
  output var  logic                                    O_BUSY_OE_N,
  output var  logic                                    O_CLAMP_TO_GROUND,
  output var  logic                                    O_AMP_CONNECT,
  output var  logic                                    O_ASYNC_MODE,
  output var  logic [odac_pkg::CHANNELS*odac_pkg::CODE_WIDTH-1:0] O_CHANNEL_CODE
);
  import odac_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Every host pin is asynchronous to the clock, so all four pass two flops.
  // The flops reset to the idle pin levels: clamp, load and reset high and
  // level select low, so no false clamp or hardware reset follows a system
  // reset while the first real pin samples are still on their way.
  logic [3:0]            pins_raw;
  logic [3:0]            pins_sync;
  logic                  clamp_n;
  logic                  load_n;
  logic                  reset_n;
  logic                  level_sel;

  assign pins_raw = {I_OUTPUT_CLAMP_N, I_LATCH_LOAD_N, I_RESET_N, I_RESET_LEVEL_SELECT};

  odac_sync #(
    .WIDTH (4),
    .INIT  (16'h000E)
  ) u_pin_sync (
    .i_clock (I_CLOCK),
    .i_rst   (I_SYS_RST),
    .i_pin   (pins_raw),
    .o_level (pins_sync)
  );

  assign clamp_n   = pins_sync[3];
  assign load_n    = pins_sync[2];
  assign reset_n   = pins_sync[1];
  assign level_sel = pins_sync[0];

  ////////////////////////////////////////////////////////////////////////
  // Update mode strap, taken from the load pin once after power-up
  // The level is captured only once the synchroniser holds real pin samples,
  // and the choice then holds until the next system reset. A host that moves
  // the load pin later cannot change the update mode.
  odac_mode_type mode;
  odac_mode_type next_mode;
  logic [1:0]    strap_count;
  logic [1:0]    next_strap_count;

  // Counts the settle cycles, then picks the mode from the load pin
  always_comb begin
    next_mode        = mode;
    next_strap_count = strap_count;
    unique case (mode)
      ODAC_WAIT_STRAP: begin
        if (strap_count == STRAP_DELAY) begin
          next_mode = load_n ? ODAC_MODE_SYNC : ODAC_MODE_ASYNC;
        end else begin
          next_strap_count = strap_count + 2'h1;
        end
      end
      ODAC_MODE_SYNC: begin
        next_mode = ODAC_MODE_SYNC;
      end
      ODAC_MODE_ASYNC: begin
        next_mode = ODAC_MODE_ASYNC;
      end
      default: begin
        next_mode = ODAC_WAIT_STRAP;
      end
    endcase
  end

  // Mode and strap counter registers
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      mode        <= ODAC_WAIT_STRAP;
      strap_count <= 2'h0;
    end else begin
      mode        <= next_mode;
      strap_count <= next_strap_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address decode of the channel data registers
  // Only the data bank is decoded here; other banks belong to registers
  // outside this block and are ignored, as are writes during power-up
  // or while the hardware reset pin is low.
  logic                      bank_hit;
  logic [CHAN_SEL_WIDTH-1:0] chan_sel;
  logic [CODE_WIDTH-1:0]     reset_code;
  logic                      transparent;
  logic                      power_up;

  assign bank_hit   = (I_ADDRESS[ADDR_WIDTH-1:BANK_SEL_POS] == DATA_BANK_SEL);
  assign chan_sel   = I_ADDRESS[CHAN_SEL_WIDTH-1:0];
  assign reset_code = level_sel ? RESET_CODE_MID : RESET_CODE_ZERO;
  assign power_up   = (mode == ODAC_WAIT_STRAP);
  // Asynchronous mode keeps latches open; synchronous mode follows the pin
  // In synchronous mode the latches open only while the synced pin is low
  assign transparent = (mode == ODAC_MODE_ASYNC) || ((mode == ODAC_MODE_SYNC) && !load_n);

  ////////////////////////////////////////////////////////////////////////
  // Per-channel data register and output latch
  // Each channel keeps a data register that the host writes and an output
  // latch that drives the converter code. The latch copies the register one
  // edge after the register takes a write, so a code reaches the output two
  // edges after its write strobe while the latches are open.
  logic [CODE_WIDTH-1:0] data_reg [CHANNELS];
  logic [CODE_WIDTH-1:0] latch    [CHANNELS];

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      logic [CODE_WIDTH-1:0] next_data;
      logic [CODE_WIDTH-1:0] next_latch;

      // Hardware reset wins over writes and latch loads
      always_comb begin
        next_data  = data_reg[ch];
        next_latch = latch[ch];
        if (!reset_n || power_up) begin
          next_data  = reset_code;
          next_latch = reset_code;
        end else begin
          if (I_WRITE && bank_hit && (chan_sel == CHAN_SEL_WIDTH'(ch))) begin
            next_data = I_DATA;
          end
          if (transparent) begin
            next_latch = data_reg[ch];
          end else begin
            next_latch = latch[ch];
          end
        end
      end

      // Data register and latch flops
      always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
          data_reg[ch] <= RESET_CODE_ZERO;
          latch[ch]    <= RESET_CODE_ZERO;
        end else begin
          data_reg[ch] <= next_data;
          latch[ch]    <= next_latch;
        end
      end

      // Code output is the latch itself, so it moves with the latch
      assign O_CHANNEL_CODE[ch*CODE_WIDTH +: CODE_WIDTH] = latch[ch];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Output switch, busy pin and mode flag
  // Every flag is registered so a pin decode never glitches an output.
  // The clamp flag needs no load pin: a low clamp pin grounds the outputs
  // whatever the load pin or the mode is doing.
  // The busy pin is open drain: its value stays low and only the enable
  // moves, low while the correction engine runs and high otherwise.
  logic next_clamp;
  logic next_connect;
  logic next_busy_oe_n;
  logic next_busy_out;
  logic next_async;

  always_comb begin
    next_clamp     = !clamp_n;
    next_connect   = clamp_n && (!load_n || (mode == ODAC_MODE_ASYNC));
    next_busy_oe_n = !I_ENGINE_ACTIVE;
    next_busy_out  = 1'b0;
    next_async     = (next_mode == ODAC_MODE_ASYNC);
  end

  // Flag registers; reset leaves the outputs grounded and the busy pin free
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_CLAMP_TO_GROUND <= 1'b1;
      O_AMP_CONNECT     <= 1'b0;
      O_BUSY_OE_N       <= 1'b1;
      O_BUSY_OUT        <= 1'b0;
      O_ASYNC_MODE      <= 1'b0;
    end else begin
      O_CLAMP_TO_GROUND <= next_clamp;
      O_AMP_CONNECT     <= next_connect;
      O_BUSY_OE_N       <= next_busy_oe_n;
      O_BUSY_OUT        <= next_busy_out; // Open drain only ever pulls low
      O_ASYNC_MODE      <= next_async;
    end
  end
endmodule
`default_nettype wire

// ### verif/odac_update_ctrl_sva.sv
// Pin-level assertions for the output update control block
`default_nettype none
module odac_update_ctrl_sva
  import odac_pkg::*;
(
  input wire logic         I_CLOCK,
  input wire logic         I_SYS_RST,
  input wire logic         I_OUTPUT_CLAMP_N,
  input wire logic         I_LATCH_LOAD_N,
  input wire logic         I_RESET_N,
  input wire logic         I_RESET_LEVEL_SELECT,
  input wire logic         I_ENGINE_ACTIVE,
  input wire logic         I_WRITE,
  input wire logic [4:0]   I_ADDRESS,
  input wire logic [15:0]  I_DATA,
  input wire logic         O_BUSY_OUT,
  input wire logic         O_BUSY_OE_N,
  input wire logic         O_CLAMP_TO_GROUND,
  input wire logic         O_AMP_CONNECT,
  input wire logic         O_ASYNC_MODE,
  input wire logic [127:0] O_CHANNEL_CODE
);
  timeunit 1ns;
  timeprecision 1ns;
  import odac_pkg::*;
  // Channel of the current write, kept apart so its history can be taken
  logic [2:0] wr_chan;
  // Edges since system reset, saturating; power-up writes are refused
  logic [2:0] settle;
  assign wr_chan = I_ADDRESS[2:0];
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      settle <= 3'h0;
    end else if (settle != 3'h7) begin
      settle <= settle + 3'h1;
    end
  end
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);
  a_busy_pull: assert property (
    I_ENGINE_ACTIVE |=> !O_BUSY_OE_N && !O_BUSY_OUT) else $error("busy not pulled");
  a_busy_free: assert property (
    !I_ENGINE_ACTIVE |=> O_BUSY_OE_N) else $error("busy not released");
  a_clamp_ground: assert property (
    (!I_OUTPUT_CLAMP_N)[*3] |=> O_CLAMP_TO_GROUND && !O_AMP_CONNECT) else $error("no clamp");
  a_connect_cause: assert property (
    O_AMP_CONNECT |-> !O_CLAMP_TO_GROUND && (O_ASYNC_MODE || !$past(I_LATCH_LOAD_N, 3)))
    else $error("connect without cause");
  a_latch_hold: assert property (
    (settle == 3'h7 && I_LATCH_LOAD_N && I_RESET_N && !O_ASYNC_MODE)[*4]
    |=> $stable(O_CHANNEL_CODE))
    else $error("latch moved while held");
  a_write_lands: assert property (
    (settle == 3'h7 && !I_LATCH_LOAD_N && I_RESET_N)[*4]
    ##0 (I_WRITE && I_ADDRESS[4:3] == 2'h1 && O_AMP_CONNECT)
    |-> ##2 16'(O_CHANNEL_CODE >> {$past(wr_chan, 2), 4'h0}) == $past(I_DATA, 2))
    else $error("write not on output");
  a_reset_level: assert property (
    (!I_RESET_N && $stable(I_RESET_LEVEL_SELECT))[*4] |-> O_CHANNEL_CODE ==
    {CHANNELS{I_RESET_LEVEL_SELECT ? RESET_CODE_MID : RESET_CODE_ZERO}}) else $error("bad reset");
  a_mode_async: assert property (
    $fell(I_SYS_RST) ##0 (!I_LATCH_LOAD_N)[*4] |=> O_ASYNC_MODE) else $error("async missed");
  a_mode_sync: assert property (
    $fell(I_SYS_RST) ##0 I_LATCH_LOAD_N[*4] |=> !O_ASYNC_MODE) else $error("sync missed");
endmodule
bind odac_update_ctrl odac_update_ctrl_sva chk (.I_CLOCK, .I_SYS_RST, .I_OUTPUT_CLAMP_N,
  .I_LATCH_LOAD_N, .I_RESET_N, .I_RESET_LEVEL_SELECT, .I_ENGINE_ACTIVE, .I_WRITE, .I_ADDRESS,
  .I_DATA, .O_BUSY_OUT, .O_BUSY_OE_N, .O_CLAMP_TO_GROUND, .O_AMP_CONNECT, .O_ASYNC_MODE,
  .O_CHANNEL_CODE);
`default_nettype wire

// ### verif/odac_host_model.sv
// Host-side pin driver standing in for the processor
`default_nettype none
module odac_host_model (
  input  wire logic i_async,
  input  wire logic i_load_req,
  input  wire logic i_reset_req,
  output var  logic o_latch_load_n,
  output var  logic o_reset_n,
  output var  logic o_chip_select_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Load pin: tied low for async, high through power-up for sync
  assign o_latch_load_n = i_async ? 1'h0 : !i_load_req;
  // Reset pin, with chip select kept high while it is used
  assign o_reset_n = !i_reset_req;
  assign o_chip_select_n = 1'h1;
endmodule
`default_nettype wire

// ### verif/octal_dac_output_update_control_bench.sv
// Self-checking bench for the output update control block
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module octal_dac_output_update_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import odac_pkg::*;
  typedef struct {int s; logic [127:0] e;} odac_note_type;
  odac_note_type q[$];
  int err_total = 0;
  int total_checks = 0;
  logic I_CLOCK = 0, I_SYS_RST = 1, clamp_n = 1, sel = 0, eng = 0, wr = 0;
  logic async_req = 0, load_req = 0, rst_req = 0, load_n, reset_n, bo, boe, cg, ac, am;
  logic [4:0] addr = 5'h00;
  logic [15:0] data = 16'h0000;
  logic [127:0] code, shadow;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, host pins and the block
  always #25 I_CLOCK = ~I_CLOCK;
  odac_host_model host (.i_async(async_req), .i_load_req(load_req), .i_reset_req(rst_req),
    .o_latch_load_n(load_n), .o_reset_n(reset_n), .o_chip_select_n());
  odac_update_ctrl dut (.I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_OUTPUT_CLAMP_N(clamp_n),
    .I_LATCH_LOAD_N(load_n), .I_RESET_N(reset_n), .I_RESET_LEVEL_SELECT(sel),
    .I_ENGINE_ACTIVE(eng), .I_WRITE(wr), .I_ADDRESS(addr), .I_DATA(data), .O_BUSY_OUT(bo),
    .O_BUSY_OE_N(boe), .O_CLAMP_TO_GROUND(cg), .O_AMP_CONNECT(ac), .O_ASYNC_MODE(am),
    .O_CHANNEL_CODE(code));
  task automatic tick(input int n);
    repeat (n) @(negedge I_CLOCK);
  endtask
  task automatic note(input int s, input logic [127:0] e);
    q.push_back('{s, e});
    tick(1);
  endtask
  // Writes a random word to every channel; ok marks an accepted address
  task automatic wr_all(input logic [4:0] base, input bit ok);
    for (int ch = 0; ch < CHANNELS; ch++) begin
      addr = base + 5'(ch);
      data = 16'($urandom);
      wr = 1'h1;
      if (ok) shadow[ch*16 +: 16] = data;
      tick(1);
    end
    wr = 1'h0;
    // Strobe stays low over one edge before the next call raises it
    tick(1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Takes every queued note at each edge, oldest first, and compares it with the settled outputs
  always @(posedge I_CLOCK) begin
    while (q.size() > 0) begin
      odac_note_type n;
      n = q.pop_front();
      if (n.s == 0) `CHK("codes", n.e, code)
      else `CHK("flags", n.e[4:0], {bo, boe, cg, ac, am})
    end
  end
  // Main sequence
  initial begin
    void'($urandom(42633));
    tick(2);
    I_SYS_RST = 1'h0;
    tick(6);
    note(1, 128'h8);
    for (int s = 0; s < 2; s++) begin
      sel = 1'(s);
      rst_req = 1'h1;
      tick(5);
      note(0, {CHANNELS{s ? RESET_CODE_MID : RESET_CODE_ZERO}});
      rst_req = 1'h0;
      tick(3);
    end
    shadow = {CHANNELS{RESET_CODE_MID}};
    wr_all(5'h08, 1);
    wr_all(5'h10, 0);
    wr_all(5'h00, 0);
    tick(3);
    note(0, {CHANNELS{RESET_CODE_MID}});
    load_req = 1'h1;
    tick(4);
    note(0, shadow);
    note(1, 128'hA);
    wr_all(5'h08, 1);
    tick(2);
    note(0, shadow);
    clamp_n = 1'h0;
    tick(4);
    note(1, 128'hC);
    clamp_n = 1'h1;
    eng = 1'h1;
    tick(4);
    note(1, 128'h2);
    eng = 1'h0;
    sel = 1'h0;
    I_SYS_RST = 1'h1;
    async_req = 1'h1;
    load_req = 1'h0;
    tick(2);
    I_SYS_RST = 1'h0;
    tick(6);
    note(1, 128'hB);
    wr_all(5'h08, 1);
    tick(2);
    note(0, shadow);
    tick(2);
    tally_and_finish();
  end
  // Watchdog against a hang
  initial begin
    tick(3000);
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
